//--- rtl/qsp_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module qsp_fifo #(
  parameter int WIDTH = 37,
  parameter int DEPTH = 2
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rstn_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [PW-1:0]    next_wr_ptr;
  logic [PW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  // Full and empty come straight from the count, never guessed
  assign in_ready_out  = (count != CNT_FULL);
  assign out_valid_out = (count != '0);
  assign out_data_out  = store[rd_ptr];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  // Pointer wrap and occupancy
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
    end
    if (push & ~pop) begin
      next_count = count + CNT_ONE;
    end else if (pop & ~push) begin
      next_count = count - CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage needs no reset; empty flag guards stale words
  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      store[wr_ptr] <= in_data_in;
    end
  end

endmodule // qsp_fifo

`default_nettype wire

//--- rtl/qsp_params.svh
`ifndef QSP_PARAMS_SVH
`define QSP_PARAMS_SVH

// Built word width: four lanes of nine bits
`define QSP_DATA_W      36
`define QSP_LANE_W      9
`define QSP_LANES       4
// Word-pair address width and depth of each of the two arrays
`define QSP_ADDR_W      20
`define QSP_DEPTH       1048576
// Read word buffer shape and the burst position tag
`define QSP_FIFO_DEPTH  2
`define QSP_TAG_FIRST   1'b0
`define QSP_TAG_SECOND  1'b1
// Reset levels of sampled pins; idle and active levels of the read output
`define QSP_SEL_IDLE    1'b1
`define QSP_CLK_IDLE    1'b0
`define QSP_KN_IDLE     1'b1
`define QSP_FLOAT       1'b1
`define QSP_DRIVE       1'b0
`define QSP_VALID_OFF   1'b0
`define QSP_VALID_ON    1'b1

`endif

//--- rtl/qsp_pkg.sv
`include "qsp_params.svh"

package qsp_pkg;

  typedef logic [`QSP_DATA_W-1:0] qsp_data_t;
  typedef logic [`QSP_ADDR_W-1:0] qsp_addr_t;
  typedef logic [`QSP_LANES-1:0]  qsp_mask_t;
  // Burst position tag above a data word
  typedef logic [`QSP_DATA_W:0]   qsp_entry_t;

  typedef enum logic [1:0] {
    QSP_RD_IDLE   = 2'b00,
    QSP_RD_FIRST  = 2'b01,
    QSP_RD_SECOND = 2'b10
  } qsp_rd_e;

endpackage

//--- rtl/qsp_sram_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "qsp_params.svh"

module qsp_sram_port (
  input  wire logic                sys_clk_in,
  input  wire logic                rstn_in,
  input  wire logic                k_in,
  input  wire logic                k_n_in,
  input  wire logic                write_port_select_n_in,
  input  wire logic                read_port_select_n_in,
  input  wire qsp_pkg::qsp_addr_t  addr_in,
  input  wire qsp_pkg::qsp_data_t  d_in,
  input  wire qsp_pkg::qsp_mask_t  byte_lane_mask_n_in,
  output qsp_pkg::qsp_data_t       q_out,
  output logic                     q_oe_n_out,
  output logic                     output_valid_flag_out,
  output logic                     echo_timing_out
);
  import qsp_pkg::*;

  // Two-stage pin synchronisers; stage one feeds only stage two
  logic       k_s1;
  logic       k_s2;
  logic       k_s3;
  logic       kn_s1;
  logic       kn_s2;
  logic       kn_s3;
  logic       wsel_s1;
  logic       wsel_s2;
  logic       rsel_s1;
  logic       rsel_s2;
  qsp_addr_t  addr_s1;
  qsp_addr_t  addr_s2;
  qsp_data_t  d_s1;
  qsp_data_t  d_s2;
  qsp_mask_t  mask_s1;
  qsp_mask_t  mask_s2;
  logic       k_rise;
  logic       kn_rise;

  // Write side state
  logic       wr_pend;
  qsp_data_t  wr_word0;
  qsp_mask_t  wr_mask0;
  logic       next_wr_pend;
  qsp_data_t  next_wr_word0;
  qsp_mask_t  next_wr_mask0;
  logic       wr_en;
  qsp_data_t  old0;
  qsp_data_t  old1;
  qsp_data_t  merged0;
  qsp_data_t  merged1;

  // Two arrays, each holding one half of every word pair
  qsp_data_t  array0 [`QSP_DEPTH];
  qsp_data_t  array1 [`QSP_DEPTH];

  // Read side state
  qsp_rd_e    rd_state;
  qsp_rd_e    next_rd_state;
  qsp_addr_t  rd_addr;
  qsp_addr_t  next_rd_addr;
  qsp_entry_t push_data;
  logic       push_valid;
  logic       push_ready;
  qsp_entry_t head;
  logic       head_valid;
  logic       pop;

  // Output state
  qsp_data_t  q;
  logic       q_oe_n;
  logic       valid_flag;
  logic       echo;
  qsp_data_t  next_q;
  logic       next_q_oe_n;
  logic       next_valid_flag;

  // Pins cross from the link; link clock is slow enough to oversample
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      k_s1    <= `QSP_CLK_IDLE;
      k_s2    <= `QSP_CLK_IDLE;
      k_s3    <= `QSP_CLK_IDLE;
      // Complement parks high; a low reset would fake a rise at release
      kn_s1   <= `QSP_KN_IDLE;
      kn_s2   <= `QSP_KN_IDLE;
      kn_s3   <= `QSP_KN_IDLE;
      wsel_s1 <= `QSP_SEL_IDLE;
      wsel_s2 <= `QSP_SEL_IDLE;
      rsel_s1 <= `QSP_SEL_IDLE;
      rsel_s2 <= `QSP_SEL_IDLE;
      addr_s1 <= '0;
      addr_s2 <= '0;
      d_s1    <= '0;
      d_s2    <= '0;
      mask_s1 <= '1;
      mask_s2 <= '1;
    end else begin
      k_s1    <= k_in;
      k_s2    <= k_s1;
      k_s3    <= k_s2;
      kn_s1   <= k_n_in;
      kn_s2   <= kn_s1;
      kn_s3   <= kn_s2;
      wsel_s1 <= write_port_select_n_in;
      wsel_s2 <= wsel_s1;
      rsel_s1 <= read_port_select_n_in;
      rsel_s2 <= rsel_s1;
      addr_s1 <= addr_in;
      addr_s2 <= addr_s1;
      d_s1    <= d_in;
      d_s2    <= d_s1;
      mask_s1 <= byte_lane_mask_n_in;
      mask_s2 <= mask_s1;
    end
  end

  // Rising edges seen after synchronising; pins aligned with them
  assign k_rise  = k_s2 & ~k_s3;
  assign kn_rise = kn_s2 & ~kn_s3;

  // Write sequencing: first word on true rise, second on complementary
  // A high select at the k rise clears the pending flag, so nothing lands
  always_comb begin
    next_wr_pend  = wr_pend;
    next_wr_word0 = wr_word0;
    next_wr_mask0 = wr_mask0;
    wr_en         = 1'b0;
    if (k_rise) begin
      next_wr_pend = ~wsel_s2;
      if (!wsel_s2) begin
        next_wr_word0 = d_s2;
        next_wr_mask0 = mask_s2;
      end
    end else if (kn_rise && wr_pend) begin
      wr_en        = 1'b1;
      next_wr_pend = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_pend  <= 1'b0;
      wr_word0 <= '0;
      wr_mask0 <= '1;
    end else begin
      wr_pend  <= next_wr_pend;
      wr_word0 <= next_wr_word0;
      wr_mask0 <= next_wr_mask0;
    end
  end

  // Lane merge: a high mask bit keeps the stored lane
  assign old0 = array0[addr_s2];
  assign old1 = array1[addr_s2];

  // Lanes are nine bits wide; no nibble masks in this build
  genvar lane;
  generate
    for (lane = 0; lane < `QSP_LANES; lane++) begin : g_lane
      assign merged0[lane*`QSP_LANE_W +: `QSP_LANE_W] =
        wr_mask0[lane] ? old0[lane*`QSP_LANE_W +: `QSP_LANE_W]
                       : wr_word0[lane*`QSP_LANE_W +: `QSP_LANE_W];
      assign merged1[lane*`QSP_LANE_W +: `QSP_LANE_W] =
        mask_s2[lane] ? old1[lane*`QSP_LANE_W +: `QSP_LANE_W]
                      : d_s2[lane*`QSP_LANE_W +: `QSP_LANE_W];
    end
  endgenerate

  // Both halves of the pair written at once on the complementary rise
  // A read taken in the same k period as a write returns the old first word; a second word held past the complementary rise is new
  always_ff @(posedge sys_clk_in) begin
    if (wr_en) begin
      array0[addr_s2] <= merged0;
      array1[addr_s2] <= merged1;
    end
  end

  // Read request: two words queued in burst order, stalled by the buffer
  // A request while a burst is still queueing is dropped; normal clocks avoid it
  always_comb begin
    next_rd_state = rd_state;
    next_rd_addr  = rd_addr;
    push_valid    = 1'b0;
    push_data     = {`QSP_TAG_FIRST, array0[rd_addr]};
    case (rd_state)
      QSP_RD_IDLE: begin
        if (k_rise && !rsel_s2) begin
          next_rd_addr  = addr_s2;
          next_rd_state = QSP_RD_FIRST;
        end
      end
      QSP_RD_FIRST: begin
        push_valid = 1'b1;
        if (push_ready) begin
          next_rd_state = QSP_RD_SECOND;
        end
      end
      QSP_RD_SECOND: begin
        push_valid = 1'b1;
        push_data  = {`QSP_TAG_SECOND, array1[rd_addr]};
        if (push_ready) begin
          next_rd_state = QSP_RD_IDLE;
        end
      end
      default: begin
        next_rd_state = QSP_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_state <= QSP_RD_IDLE;
      rd_addr  <= '0;
    end else begin
      rd_state <= next_rd_state;
      rd_addr  <= next_rd_addr;
    end
  end

  // Buffer absorbs the overlap of back-to-back bursts
  qsp_fifo #(
    .WIDTH (`QSP_DATA_W + 1),
    .DEPTH (`QSP_FIFO_DEPTH)
  ) u_rd_fifo (
    .sys_clk_in    (sys_clk_in),
    .rstn_in       (rstn_in),
    .in_data_in    (push_data),
    .in_valid_in   (push_valid),
    .in_ready_out  (push_ready),
    .out_data_out  (head),
    .out_valid_out (head_valid),
    .out_ready_in  (pop)
  );

  // A word leaves only on the edge matching its burst position
  assign pop = head_valid &
               ((k_rise & (head[`QSP_DATA_W] == `QSP_TAG_FIRST)) |
                (kn_rise & (head[`QSP_DATA_W] == `QSP_TAG_SECOND)));

  // Output launch; floats on any edge with no word due
  // A stalled buffer floats the bus rather than repeat a word
  always_comb begin
    next_q          = q;
    next_q_oe_n     = q_oe_n;
    next_valid_flag = valid_flag;
    if (k_rise || kn_rise) begin
      if (pop) begin
        next_q          = head[`QSP_DATA_W-1:0];
        next_q_oe_n     = `QSP_DRIVE;
        next_valid_flag = `QSP_VALID_ON;
      end else begin
        next_q_oe_n     = `QSP_FLOAT;
        next_valid_flag = `QSP_VALID_OFF;
      end
    end
  end

  // Echo copy shares the launch register stage so edges line up
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q          <= '0;
      q_oe_n     <= `QSP_FLOAT;
      valid_flag <= `QSP_VALID_OFF;
      echo       <= `QSP_CLK_IDLE;
    end else begin
      q          <= next_q;
      q_oe_n     <= next_q_oe_n;
      valid_flag <= next_valid_flag;
      echo       <= k_s2;
    end
  end

  // Ports are plain copies of the launch registers
  assign q_out                 = q;
  assign q_oe_n_out            = q_oe_n;
  assign output_valid_flag_out = valid_flag;
  assign echo_timing_out       = echo;

endmodule // qsp_sram_port

`default_nettype wire

//--- testbench/qsp_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none

module qsp_ctrl_model (
  input  wire logic          sys_clk_in,
  output logic               k_out,
  output logic               k_n_out,
  output logic               wsel_n_out,
  output logic               rsel_n_out,
  output qsp_pkg::qsp_addr_t addr_out,
  output qsp_pkg::qsp_data_t d_out,
  output qsp_pkg::qsp_mask_t mask_n_out
);
  import qsp_pkg::*;
  // Idle: both ports deselected, clocks parked
  initial begin
    k_out = 1'b0;
    k_n_out = 1'b1;
    wsel_n_out = 1'b1;
    rsel_n_out = 1'b1;
    addr_out = '0;
    d_out = '0;
    mask_n_out = 4'hf;
  end
  // One link period; pins lead each rise by a cycle, hold three after
  task automatic link(input logic wr_n, input logic rd_n,
    input qsp_addr_t ra, input qsp_addr_t wa, input qsp_data_t d0,
    input qsp_mask_t m0, input qsp_data_t d1, input qsp_mask_t m1);
    @(negedge sys_clk_in);
    wsel_n_out = wr_n;
    rsel_n_out = rd_n;
    addr_out = ra;
    d_out = d0;
    mask_n_out = m0;
    @(negedge sys_clk_in);
    k_out = 1'b1;
    k_n_out = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    addr_out = wa;
    d_out = d1;
    mask_n_out = m1;
    @(negedge sys_clk_in);
    k_out = 1'b0;
    k_n_out = 1'b1;
    repeat (2) @(negedge sys_clk_in);
  endtask
endmodule // qsp_ctrl_model

`default_nettype wire

//--- testbench/qsp_port_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none

module qsp_port_chk (
  input wire logic               sys_clk_in,
  input wire logic               rstn_in,
  input wire logic               k_in,
  input wire logic               read_port_select_n_in,
  input wire logic               write_port_select_n_in,
  input wire qsp_pkg::qsp_data_t q_out,
  input wire logic               q_oe_n_out,
  input wire logic               output_valid_flag_out,
  input wire logic               echo_timing_out
);
  import qsp_pkg::*;
  logic        vld;
  logic        k_q;
  logic        rd_req;
  logic [19:0] req_hist;
  logic [19:0] next_req_hist;
  assign vld    = output_valid_flag_out;
  // Read request pulse at each k rise seen with read select low
  assign rd_req = k_in && !k_q && !read_port_select_n_in;
  // One bit per cycle of age, so back-to-back bursts keep their own request
  always_comb begin
    next_req_hist = {req_hist[18:0], rd_req};
  end
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      req_hist <= 20'h00000;
      k_q      <= 1'b0;
    end else begin
      req_hist <= next_req_hist;
      k_q      <= k_in;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  reset_vals_a: assert property (
    $rose(rstn_in) |-> q_oe_n_out && !vld) else $error("bus not floating");
  oe_tie_a: assert property (
    q_oe_n_out != vld) else $error("enable and valid disagree");
  q_hold_a: assert property (
    !vld |-> $stable(q_out)) else $error("data moved while idle");
  burst_len_a: assert property (
    $rose(vld) |-> vld[*7]) else $error("burst shorter than two words");
  read_lat_a: assert property (
    $rose(k_in) && !read_port_select_n_in |-> ##[8:14] vld)
    else $error("read word not launched");
  valid_cause_a: assert property (
    $rose(vld) |-> req_hist[14:8] != 7'h00)
    else $error("valid without request");
  float_idle_a: assert property (
    req_hist == 20'h00000 |-> !vld) else $error("bus driven without read");
  echo_rise_a: assert property (
    $rose(k_in) |-> ##[2:4] echo_timing_out) else $error("echo late");
  echo_fall_a: assert property (
    $fell(k_in) |-> ##[2:4] !echo_timing_out) else $error("echo stuck");
  cover property ($rose(vld));
  cover property ($rose(k_in) && !write_port_select_n_in);
  cover property ($rose(k_in) && read_port_select_n_in);
  cover property (vld && rd_req);
endmodule // qsp_port_chk

bind qsp_sram_port qsp_port_chk i_qsp_port_chk (
  .sys_clk_in(sys_clk_in),
  .rstn_in(rstn_in),
  .k_in(k_in),
  .read_port_select_n_in(read_port_select_n_in),
  .write_port_select_n_in(write_port_select_n_in),
  .q_out(q_out),
  .q_oe_n_out(q_oe_n_out),
  .output_valid_flag_out(output_valid_flag_out),
  .echo_timing_out(echo_timing_out)
);

`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import qsp_pkg::*;
  logic      sys_clk_in = 1'b0;
  logic      rstn_in = 1'b0;
  logic      k, k_n, wr_n, rd_n, oe_n, vld, echo, echo_q;
  logic[1:0] smp = 2'b00;
  qsp_addr_t addr;
  qsp_data_t d, q;
  qsp_mask_t m;
  qsp_data_t got[$];
  int        fail_count = 0;
  int        n_tests = 0;

  always #10 sys_clk_in = ~sys_clk_in;

  qsp_ctrl_model i_qsp_ctrl_model (.sys_clk_in(sys_clk_in), .k_out(k),
    .k_n_out(k_n), .wsel_n_out(wr_n), .rsel_n_out(rd_n), .addr_out(addr),
    .d_out(d), .mask_n_out(m));
  qsp_sram_port i_qsp_sram_port (.sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in), .k_in(k), .k_n_in(k_n),
    .write_port_select_n_in(wr_n), .read_port_select_n_in(rd_n),
    .addr_in(addr), .d_in(d), .byte_lane_mask_n_in(m), .q_out(q),
    .q_oe_n_out(oe_n), .output_valid_flag_out(vld),
    .echo_timing_out(echo));

  // Catch each word mid-window, two cycles after the echo moves
  always @(negedge sys_clk_in) begin
    echo_q <= echo;
    smp <= {smp[0], echo_q !== echo};
    if (smp[1] && vld === 1'b1) got.push_back(q);
  end

  task automatic chk(input string nm, input qsp_data_t e, input qsp_data_t g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic idle();
    i_qsp_ctrl_model.link(1'b1, 1'b1, 20'ha5a5a, 20'h5a5a5, '1, 4'h0, '0, 4'h0);
  endtask

  task automatic wr(input qsp_addr_t a, input qsp_data_t d0,
    input qsp_mask_t m0, input qsp_data_t d1, input qsp_mask_t m1);
    i_qsp_ctrl_model.link(1'b0, 1'b1, ~a, a, d0, m0, d1, m1);
  endtask

  // Read one pair, then confirm the bus floats again
  task automatic rd(input qsp_addr_t a, input qsp_data_t e0, input qsp_data_t e1);
    got.delete();
    i_qsp_ctrl_model.link(1'b1, 1'b0, a, ~a, ~e0, 4'h0, ~e1, 4'h0);
    idle();
    idle();
    chk("count", 36'h2, 36'(got.size()));
    chk("word0", e0, got[0]);
    chk("word1", e1, got[1]);
    chk("float", 36'h1, {35'h0, oe_n});
  endtask

  task automatic t_basic();
    wr(20'h00005, 36'h1_2345_6789, 4'h0, 36'hf_edcb_a987, 4'h0);
    rd(20'h00005, 36'h1_2345_6789, 36'hf_edcb_a987);
    $display("basic test done");
  endtask

  task automatic t_lanes();
    qsp_data_t p, n, lm;
    p = 36'h9_a5a5_a5a5;
    n = 36'h6_3c3c_3c3c;
    for (int i = 0; i < 4; i++) begin
      lm = 36'h1ff << (9 * i);
      wr(20'hfffff, p, 4'h0, p, 4'h0);
      wr(20'hfffff, n, ~(4'h1 << i), n, 4'h1 << i);
      rd(20'hfffff, (p & ~lm) | (n & lm), (n & ~lm) | (p & lm));
    end
    $display("lanes test done");
  endtask

  task automatic t_desel();
    wr(20'h00a00, 36'h0_1111_2222, 4'h0, 36'h0_3333_4444, 4'h0);
    got.delete();
    i_qsp_ctrl_model.link(1'b1, 1'b1, 20'h00a00, 20'h00a00, '1, 4'h0, '1,
      4'h0);
    idle();
    chk("no words", 36'h0, 36'(got.size()));
    rd(20'h00a00, 36'h0_1111_2222, 36'h0_3333_4444);
    $display("deselect test done");
  endtask

  task automatic t_b2b();
    got.delete();
    i_qsp_ctrl_model.link(1'b1, 1'b0, 20'h00005, 20'h0, '0, 4'hf, '0, 4'hf);
    i_qsp_ctrl_model.link(1'b1, 1'b0, 20'h00a00, 20'h0, '0, 4'hf, '0, 4'hf);
    idle();
    idle();
    chk("b2b count", 36'h4, 36'(got.size()));
    chk("b2b word0", 36'h1_2345_6789, got[0]);
    chk("b2b word1", 36'hf_edcb_a987, got[1]);
    chk("b2b word2", 36'h0_1111_2222, got[2]);
    chk("b2b word3", 36'h0_3333_4444, got[3]);
    $display("back to back test done");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (3) @(posedge sys_clk_in);
    chk("reset oe_n", 36'h1, {35'h0, oe_n});
    chk("reset valid", 36'h0, {35'h0, vld});
    @(negedge sys_clk_in);
    rstn_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    idle();
    t_basic();
    t_lanes();
    t_desel();
    t_b2b();
    end_sim();
  end
endmodule // testbench

`default_nettype wire
